// >>> src/pbs_defs.svh
// Purpose: offsets, field positions, reset values of the power budget and status bank
// Assumes: byte addresses on a 12-bit Wishbone address
// Notes:   included by bare name
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PBS_OFF_SELECT      12'h284
`define PBS_OFF_READ_PORT   12'h288
`define PBS_OFF_CAPABILITY  12'h28C
`define PBS_OFF_DATA_VALUE  12'h300
`define PBS_OFF_STATUS      12'h400
`define PBS_OFF_CONTROL     12'h404

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PBS_BIT_SYS_ALLOC   0
`define PBS_BIT_LOCK_WE     3
`define PBS_BIT_DV_UNLOCK   4
`define PBS_NUM_WORDS       8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PBS_RST_SPEC_MODE   2'h1
`define PBS_RST_MARKER      4'h0
`define PBS_RST_SELECT      8'h00

`endif

// >>> src/pbs_pkg.sv
// Purpose: state types and helpers of the power budget and status bank
// Assumes: nothing beyond the defs header
// Notes:   one packed struct each for the pbs_regs and pbs_store state; pbs_sync declares its own
package pbs_pkg;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        sys_alloc;
        logic [7:0]  data_value_select;
        logic [2:0]  mode;
        logic [4:0]  straps;
        logic [1:0]  base_spec_mode;
        logic [2:0]  upstream_lock_state;
        logic [3:0]  marker;
        logic        lockable_write_enable;
        logic        data_value_unlock;
    } pbs_top_t;

    typedef struct packed {
        logic [7:0][31:0] budget_word;
    } pbs_store_t;

    // byte-lane merge for Wishbone sel
    function automatic logic [31:0] pbs_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : pbs_merge

endpackage : pbs_pkg

// >>> src/pbs_store_if.sv
// Purpose: write port and word view between bank and budget store
// Assumes: single clock
// Notes:   words are visible all at once for the read muxes
`timescale 1ns/1ps
interface pbs_store_if;
    logic             we;
    logic [2:0]       idx;
    logic [31:0]      wdata;
    logic [3:0]       wsel;
    logic [7:0][31:0] word;

    modport bank  (output we, idx, wdata, wsel, input word);
    modport store (input we, idx, wdata, wsel, output word);
endinterface : pbs_store_if

// >>> src/pbs_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: slow static pins
// Notes:   only the second stage is visible
`timescale 1ns/1ps
module pbs_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk_i,
    // level in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pbs_sync_t;

    pbs_sync_t q;
    pbs_sync_t next_q;

    always_comb begin
        next_q.s1 = d_i;
        next_q.s2 = q.s1;
    end

    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    assign q_o = q.s2;
endmodule : pbs_sync

// >>> src/pbs_store.sv
// Purpose: eight sticky budget words
// Assumes: writes gated upstream by the unlock bit
// Notes:   no reset at all; contents undefined until written
`timescale 1ns/1ps
module pbs_store
    import pbs_pkg::*;
(
    // clock
    input  wire logic clk_i,
    // bank side
    pbs_store_if.store st
);
    pbs_store_t q;
    pbs_store_t next_q;

    always_comb begin
        next_q = q;
        if (st.we) begin
            next_q.budget_word[st.idx] = pbs_merge(q.budget_word[st.idx], st.wdata, st.wsel);
        end
    end

    // no reset: hot and fundamental resets both leave contents alone
    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    assign st.word = q.budget_word;

    chk_word_write: assert property (@(posedge clk_i)
        st.we |=> q.budget_word[$past(st.idx)] == pbs_merge($past(q.budget_word[st.idx]),
                                                           $past(st.wdata), $past(st.wsel)))
        else $error("budget word write not stored");
endmodule : pbs_store

// >>> src/pbs_regs.sv
// Purpose: power budget tail and switch status register bank on classic Wishbone
// Assumes: rst_i is the fundamental reset, synchronous to clk_i; hot_rst_i is same-domain
// Notes:   ack one cycle after request; write takes effect on the ack edge
//
// Notes on behaviour
// - capability bit 0 flags power already in system budget, lockable
// - eight sticky 32-bit budget words at 0x300, kept through both resets, undefined until written
// - budget words written only while data value unlock set, else ignored
// - status bits 2:0 follow mode pins; 0 normal, 1 EEPROM init
// - status bits 5..9 capture five straps during fundamental reset
// - base spec mode bits 11:10 lockable; code 1 compliant
// - status bits 22:20 report upstream lock state, read-only
// - marker bits 31:28 sticky rw, cleared only by fundamental reset
// - data value unlock is control bit 4 at 0x404, all ports
// - lockable fields writable only while control bit 3 set
// - read port returns selected word, zero when select above 7
`timescale 1ns/1ps
`include "pbs_defs.svh"
module pbs_regs
    import pbs_pkg::*;
(
    // clock and resets
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hot_rst_i,
    // wishbone slave
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // pins and straps
    input  wire logic [2:0]  operating_mode_pins_i,
    input  wire logic        downstream_common_clock_strap_i,
    input  wire logic        upstream_common_clock_strap_i,
    input  wire logic        master_serial_slow_strap_i,
    input  wire logic        refclock_mode_strap_i,
    input  wire logic        halt_after_reset_strap_i,
    // switch core
    input  wire logic [2:0]  upstream_lock_state_i,
    output logic             system_allocated_flag_o,
    output logic             data_value_unlock_o,
    output logic             lockable_write_enable_o
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] pins_raw;
    logic [7:0] pins_s;

    assign pins_raw = {halt_after_reset_strap_i, refclock_mode_strap_i,
                       master_serial_slow_strap_i, upstream_common_clock_strap_i,
                       downstream_common_clock_strap_i, operating_mode_pins_i};

    pbs_sync #(.W(8)) u_sync (
        .clk_i (clk_i),
        .d_i   (pins_raw),
        .q_o   (pins_s)
    );

    // ----------------------------------------------------------------
    // budget word store
    // ----------------------------------------------------------------
    pbs_store_if st ();

    pbs_store u_store (
        .clk_i (clk_i),
        .st    (st)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    pbs_top_t q;
    pbs_top_t next_q;

    logic        req;
    logic        wr;
    logic        hit_sel;
    logic        hit_port;
    logic        hit_cap;
    logic        hit_dv;
    logic        hit_sts;
    logic        hit_ctl;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    logic [31:0] port_word;

    assign req      = wb_cyc_i & wb_stb_i;
    assign wr       = req & q.ack & wb_we_i;
    assign hit_sel  = wb_adr_i[11:2] == 10'(`PBS_OFF_SELECT >> 2);
    assign hit_port = wb_adr_i[11:2] == 10'(`PBS_OFF_READ_PORT >> 2);
    assign hit_cap  = wb_adr_i[11:2] == 10'(`PBS_OFF_CAPABILITY >> 2);
    assign hit_dv   = wb_adr_i[11:5] == 7'(`PBS_OFF_DATA_VALUE >> 5);
    assign hit_sts  = wb_adr_i[11:2] == 10'(`PBS_OFF_STATUS >> 2);
    assign hit_ctl  = wb_adr_i[11:2] == 10'(`PBS_OFF_CONTROL >> 2);

    assign status_word = {q.marker, 5'h00, q.upstream_lock_state, 8'h00,
                          q.base_spec_mode, q.straps, 2'h0, q.mode};

    assign port_word = (q.data_value_select < 8'(`PBS_NUM_WORDS))
                     ? st.word[q.data_value_select[2:0]] : 32'h0000_0000;

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_cap) begin
            rd_word[`PBS_BIT_SYS_ALLOC] = q.sys_alloc;
        end else if (hit_sel) begin
            rd_word[7:0] = q.data_value_select;
        end else if (hit_port) begin
            rd_word = port_word;
        end else if (hit_dv) begin
            rd_word = st.word[wb_adr_i[4:2]];
        end else if (hit_sts) begin
            rd_word = status_word;
        end else if (hit_ctl) begin
            rd_word[`PBS_BIT_LOCK_WE]  = q.lockable_write_enable;
            rd_word[`PBS_BIT_DV_UNLOCK] = q.data_value_unlock;
        end
    end

    // ----------------------------------------------------------------
    // store write port
    // ----------------------------------------------------------------
    // gated by unlock
    assign st.we    = wr & hit_dv & q.data_value_unlock;
    assign st.idx   = wb_adr_i[4:2];
    assign st.wdata = wb_dat_i;
    assign st.wsel  = wb_sel_i;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_q = q;

        // ack for one cycle; read data latched with it
        next_q.ack = req & ~q.ack;
        if (req & ~q.ack) begin
            next_q.rdata = rd_word;
        end

        next_q.mode = pins_s[2:0];

        next_q.upstream_lock_state = upstream_lock_state_i;

        if (rst_i) begin
            next_q.straps = pins_s[7:3];
        end

        if (wr) begin
            if (hit_cap && q.lockable_write_enable && wb_sel_i[0]) begin
                next_q.sys_alloc = wb_dat_i[`PBS_BIT_SYS_ALLOC];
            end
            if (hit_sel && wb_sel_i[0]) begin
                next_q.data_value_select = wb_dat_i[7:0];
            end
            if (hit_sts && q.lockable_write_enable && wb_sel_i[1]) begin
                next_q.base_spec_mode = wb_dat_i[11:10];
            end
            if (hit_sts && wb_sel_i[3]) begin
                next_q.marker = wb_dat_i[31:28];
            end
            if (hit_ctl && wb_sel_i[0]) begin
                next_q.lockable_write_enable = wb_dat_i[`PBS_BIT_LOCK_WE];
                if (q.lockable_write_enable) begin
                    next_q.data_value_unlock = wb_dat_i[`PBS_BIT_DV_UNLOCK];
                end
            end
        end

        // hot reset spares sticky fields: marker, unlock bits, words
        if (hot_rst_i) begin
            next_q.sys_alloc         = 1'b0;
            next_q.data_value_select = `PBS_RST_SELECT;
        end

        if (rst_i) begin
            next_q.ack                   = 1'b0;
            next_q.rdata                 = 32'h0000_0000;
            next_q.sys_alloc             = 1'b0;
            next_q.data_value_select     = `PBS_RST_SELECT;
            next_q.base_spec_mode        = `PBS_RST_SPEC_MODE;
            next_q.marker                = `PBS_RST_MARKER;
            next_q.lockable_write_enable = 1'b0;
            next_q.data_value_unlock     = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_ack_o                = q.ack;
    assign wb_dat_o                = q.rdata;
    assign system_allocated_flag_o = q.sys_alloc;
    assign data_value_unlock_o     = q.data_value_unlock;
    assign lockable_write_enable_o = q.lockable_write_enable;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_sa_write_set: assert property (
        wr && hit_cap && q.lockable_write_enable && wb_sel_i[0] && !hot_rst_i
        |=> q.sys_alloc == $past(wb_dat_i[0]))
        else $error("system allocated flag not written");

    chk_sa_locked_hold: assert property (
        wr && hit_cap && !q.lockable_write_enable && !hot_rst_i |=> $stable(q.sys_alloc))
        else $error("locked flag changed");

    chk_dv_write_gate: assert property (
        wr && hit_dv && !q.data_value_unlock
        |=> st.word[$past(wb_adr_i[4:2])] == $past(st.word[wb_adr_i[4:2]]))
        else $error("budget word written while locked");

    chk_dvu_locked_hold: assert property (
        wr && hit_ctl && !q.lockable_write_enable |=> $stable(q.data_value_unlock))
        else $error("unlock bit changed while locked");

    chk_mode_pin_follow: assert property (
        !$past(rst_i, 3) |-> q.mode == $past(operating_mode_pins_i, 3))
        else $error("mode field does not follow pins");

    chk_strap_hold_run: assert property (
        !$past(rst_i) |-> $stable(q.straps))
        else $error("strap changed outside reset");

    chk_spec_locked_hold: assert property (
        wr && hit_sts && !q.lockable_write_enable |=> $stable(q.base_spec_mode))
        else $error("spec mode changed while locked");

    chk_lock_state_live: assert property (
        q.upstream_lock_state == $past(upstream_lock_state_i))
        else $error("lock state not mirrored");

    chk_marker_hot_keep: assert property (
        hot_rst_i && !(wr && hit_sts) |=> $stable(q.marker))
        else $error("marker lost on hot reset");

    chk_port_select_zero: assert property (
        req && !q.ack && hit_port && q.data_value_select > 8'h07 |=> wb_dat_o == 32'h0000_0000)
        else $error("read port not zero for large select");

    chk_resv_cap_zero: assert property (
        req && !q.ack && (hit_cap || hit_ctl) |=> wb_dat_o[31:5] == 27'h0 && wb_dat_o[2:1] == 2'h0)
        else $error("reserved bits read nonzero");

    chk_resv_status_zero: assert property (
        req && !q.ack && hit_sts
        |=> wb_dat_o[27:23] == 5'h00 && wb_dat_o[19:12] == 8'h00 && wb_dat_o[4:3] == 2'h0)
        else $error("reserved status bits read nonzero");

    chk_resv_select_zero: assert property (
        req && !q.ack && hit_sel |=> wb_dat_o[31:8] == 24'h00_0000)
        else $error("reserved select bits read nonzero");

    chk_port_select_word: assert property (
        req && !q.ack && hit_port && q.data_value_select < 8'h08
        |=> wb_dat_o == $past(st.word[q.data_value_select[2:0]]))
        else $error("read port not the selected word");

    chk_spec_write_set: assert property (
        wr && hit_sts && q.lockable_write_enable && wb_sel_i[1] |=> q.base_spec_mode == $past(wb_dat_i[11:10]))
        else $error("spec mode not written");

    chk_marker_write_set: assert property (
        wr && hit_sts && wb_sel_i[3] |=> q.marker == $past(wb_dat_i[31:28]))
        else $error("marker not written");

    chk_dvu_write_set: assert property (
        wr && hit_ctl && q.lockable_write_enable && wb_sel_i[0]
        |=> q.data_value_unlock == $past(wb_dat_i[`PBS_BIT_DV_UNLOCK]))
        else $error("unlock bit not written");

    chk_hot_clear_flag: assert property (
        hot_rst_i |=> !q.sys_alloc && q.data_value_select == 8'h00)
        else $error("hot reset left flag or select");

    chk_ack_one_cycle: assert property (
        req && !q.ack |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");

endmodule : pbs_regs

// >>> verification/pbs_regs_tb.sv
// Purpose: self-checking bench for the power budget and switch status bank
// Assumes: ack one cycle after a request; straps and mode pins synchronised by two flops
// Notes:   budget words hold x until written, so each is written before it is read
`timescale 1ns/1ps
`include "pbs_defs.svh"
module pbs_regs_tb
    import pbs_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        hot_rst_i = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic [2:0]  mode = 3'h1;
    logic [4:0]  strap = 5'h16;
    logic [2:0]  lock = 3'h0;
    logic        flag;
    logic        unlock;
    logic        lwe;
    logic [31:0] v;
    int          fail_count = 0;
    int          n_compared = 0;

    pbs_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .hot_rst_i(hot_rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .operating_mode_pins_i(mode), .downstream_common_clock_strap_i(strap[0]),
        .upstream_common_clock_strap_i(strap[1]), .master_serial_slow_strap_i(strap[2]),
        .refclock_mode_strap_i(strap[3]), .halt_after_reset_strap_i(strap[4]),
        .upstream_lock_state_i(lock), .system_allocated_flag_o(flag), .data_value_unlock_o(unlock),
        .lockable_write_enable_o(lwe));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (fail_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // request held until ack is sampled high; bounded wait
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        sel <= s;
        we <= w;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
        end
        v = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        check(v, exp);
    endtask : rd_chk

    function automatic logic [31:0] st(input logic [3:0] mk, input logic [2:0] lk, input logic [1:0] sp,
                                       input logic [4:0] sr, input logic [2:0] md);
        return {mk, 5'h00, lk, 8'h00, sp, sr, 2'h0, md};
    endfunction : st

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_lockable();
        rd_chk(`PBS_OFF_STATUS, st(4'h0, 3'h0, 2'h1, 5'h16, 3'h1));
        rd_chk(`PBS_OFF_CAPABILITY, 32'h0);
        bus(1'b1, 12'h010, 32'hFFFFFFFF, 4'hF);
        rd_chk(12'h010, 32'h0);
        bus(1'b1, `PBS_OFF_CAPABILITY, 32'h1, 4'hF);
        rd_chk(`PBS_OFF_CAPABILITY, 32'h0);
        bus(1'b1, `PBS_OFF_CONTROL, 32'h10, 4'hF);
        rd_chk(`PBS_OFF_CONTROL, 32'h0);
        bus(1'b1, `PBS_OFF_CONTROL, 32'h8, 4'hF);
        bus(1'b1, `PBS_OFF_CAPABILITY, 32'hFFFFFFFF, 4'hF);
        rd_chk(`PBS_OFF_CAPABILITY, 32'h1);
        check({31'h0, flag}, 32'h1);
        bus(1'b1, `PBS_OFF_STATUS, 32'hFFFFFFFF, 4'hF);
        rd_chk(`PBS_OFF_STATUS, st(4'hF, 3'h0, 2'h3, 5'h16, 3'h1));
        bus(1'b1, `PBS_OFF_CONTROL, 32'h18, 4'hF);
        rd_chk(`PBS_OFF_CONTROL, 32'h18);
        check({30'h0, unlock, lwe}, 32'h3);
    endtask : t_lockable

    task automatic t_words();
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, `PBS_OFF_DATA_VALUE + 12'(4 * i), 32'hA5C30000 | i, 4'hF);
        end
        bus(1'b1, `PBS_OFF_DATA_VALUE + 12'h1C, 32'h0000FF00, 4'h2);
        bus(1'b1, `PBS_OFF_CONTROL, 32'h8, 4'hF);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, `PBS_OFF_DATA_VALUE + 12'(4 * i), 32'h0, 4'hF);
            bus(1'b1, `PBS_OFF_SELECT, 32'(i), 4'hF);
            rd_chk(`PBS_OFF_READ_PORT, (i == 7) ? 32'hA5C3FF07 : (32'hA5C30000 | i));
            rd_chk(`PBS_OFF_DATA_VALUE + 12'(4 * i), (i == 7) ? 32'hA5C3FF07 : (32'hA5C30000 | i));
        end
        bus(1'b1, `PBS_OFF_SELECT, 32'h8, 4'hF);
        rd_chk(`PBS_OFF_READ_PORT, 32'h0);
        bus(1'b1, `PBS_OFF_SELECT, 32'hFFFFFFFF, 4'hF);
        rd_chk(`PBS_OFF_SELECT, 32'hFF);
        rd_chk(`PBS_OFF_READ_PORT, 32'h0);
    endtask : t_words

    task automatic t_pins();
        // mode pins left alone outside fundamental reset
        for (int i = 2; i < 6; i++) begin
            lock <= 3'(i);
            repeat (4) @(posedge clk_i);
            rd_chk(`PBS_OFF_STATUS, st(4'hF, 3'(i), 2'h3, 5'h16, 3'h1));
        end
        lock <= 3'h0;
        repeat (4) @(posedge clk_i);
        rd_chk(`PBS_OFF_STATUS, st(4'hF, 3'h0, 2'h3, 5'h16, 3'h1));
    endtask : t_pins

    task automatic t_hot();
        hot_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        hot_rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(`PBS_OFF_STATUS, st(4'hF, 3'h0, 2'h3, 5'h16, 3'h1));
        rd_chk(`PBS_OFF_CAPABILITY, 32'h0);
        rd_chk(`PBS_OFF_SELECT, 32'h0);
        rd_chk(`PBS_OFF_CONTROL, 32'h8);
    endtask : t_hot

    task automatic t_fund();
        strap <= 5'h09;
        repeat (3) @(posedge clk_i);
        // mode pins change only while fundamental reset is held
        rst_i <= 1'b1;
        mode <= 3'h0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        strap <= 5'h16;
        repeat (4) @(posedge clk_i);
        rd_chk(`PBS_OFF_STATUS, st(4'h0, 3'h0, 2'h1, 5'h09, 3'h0));
        rd_chk(`PBS_OFF_CONTROL, 32'h0);
        check({29'h0, flag, unlock, lwe}, 32'h0);
        rd_chk(`PBS_OFF_DATA_VALUE, 32'hA5C30000);
        bus(1'b1, `PBS_OFF_STATUS, 32'hA0000C00, 4'hF);
        rd_chk(`PBS_OFF_STATUS, st(4'hA, 3'h0, 2'h1, 5'h09, 3'h0));
    endtask : t_fund

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_lockable();
        t_words();
        t_pins();
        t_hot();
        t_fund();
        complete_run();
    end

    // whole run is about 280 cycles
    initial begin
        #(100 * 5000);
        fail_count++;
        complete_run();
    end
endmodule : pbs_regs_tb
